// file: hdl/or_ret_cfg.svh
// constants for the or/return execution block
// included by the package and the design modules
`ifndef OR_RET_CFG_SVH
`define OR_RET_CFG_SVH
`define PC_W          11
`define STACK_DEPTH   8
`define DATA_W        8
`define ADDR_W        8
`define PC_RESET      11'h000
`define ACC_RESET     8'h00
`define IRQ_VECTOR    11'h004
`endif

// file: hdl/or_ret_exec.sv
// execution of idle, bitwise or and return instructions
// assumes decoded opcode and operands valid each exec cycle, data memory read
// combinational, and interrupt request synchronous to core_clk_in
`timescale 1ns/1ps
`include "or_ret_cfg.svh"
module or_ret_exec
  import or_ret_pkg::*;
#(
  parameter int PC_W  = `PC_W,
  parameter int DEPTH = `STACK_DEPTH
) (
  input  wire logic                core_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic                op_valid_in,
  input  wire op_t                 op_in,
  input  wire logic [`DATA_W-1:0]  literal_in,
  input  wire logic [`ADDR_W-1:0]  mem_addr_in,
  input  wire logic [`DATA_W-1:0]  mem_rdata_in,
  input  wire logic                irq_pending_in,
  output logic                     ready_out,
  output logic [PC_W-1:0]          pc_out,
  output logic [`DATA_W-1:0]       acc_out,
  output logic                     zero_flag_out,
  output logic                     int_enable_out,
  output logic                     mem_we_out,
  output logic [`ADDR_W-1:0]       mem_waddr_out,
  output logic [`DATA_W-1:0]       mem_wdata_out
);
  if (PC_W < 4 || PC_W > 16) begin : g_bad_pc_w
    $error("or_ret_exec pc width out of range");
  end

  state_t             state_q, state_d;
  logic [PC_W-1:0]    pc_q, pc_d;
  logic [`DATA_W-1:0] acc_q, acc_d;
  logic               z_q, z_d, emi_q, emi_d;
  logic               we_q;
  logic [`ADDR_W-1:0] waddr_q;
  logic [`DATA_W-1:0] wdata_q;
  logic [PC_W-1:0]    stack_top;

  wire exec      = op_valid_in && state_q == ST_EXEC;
  wire is_ret    = op_in inside {OPC_RET, OPC_RETX, OPC_INTERRUPT_EXIT_OP};
  wire do_pop    = exec && is_ret;
  wire [`DATA_W-1:0] or_mem = acc_q | mem_rdata_in;
  wire [`DATA_W-1:0] or_lit = acc_q | literal_in;
  // interrupt taken after interrupt_exit_op, before the main program resumes
  wire take_irq  = exec && op_in == OPC_INTERRUPT_EXIT_OP && irq_pending_in;
  // one-hot decode of the instruction being executed
  wire is_idle   = exec && op_in == OPC_IDLE;
  wire is_orm2a  = exec && op_in == OPC_ORM2A;
  wire is_orx2a  = exec && op_in == OPC_ORX2A;
  wire is_ora2m  = exec && op_in == OPC_ORA2M;
  wire is_ret0   = exec && op_in == OPC_RET;
  wire is_retx   = exec && op_in == OPC_RETX;
  wire is_interrupt_exit_op   = exec && op_in == OPC_INTERRUPT_EXIT_OP;

  // on irq entry the popped address is pushed straight back, so the stack
  // keeps one copy of the return address and its depth is unchanged
  ret_stack #(.WIDTH(PC_W), .DEPTH(DEPTH)) u_stack (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .push_in     (take_irq),
    .push_data_in(stack_top),
    .pop_in      (do_pop),
    .top_out     (stack_top)
  );

  // next state: pc steps by one on each executed op unless a return reloads it, otherwise holds
  always_comb begin
    state_d = ST_EXEC;
    pc_d    = pc_q;
    acc_d   = acc_q;
    z_d     = z_q;
    emi_d   = emi_q;
    if (exec) begin
      pc_d = pc_q + 1'b1;
      unique case (op_in)
        OPC_IDLE: ;
        OPC_ORM2A: begin
          acc_d = or_mem;
          z_d   = or_mem == '0;
        end
        OPC_ORX2A: begin
          acc_d = or_lit;
          z_d   = or_lit == '0;
        end
        OPC_ORA2M: z_d = or_mem == '0;
        OPC_RET: begin
          pc_d    = stack_top;
          state_d = ST_DUMMY;
        end
        OPC_RETX: begin
          pc_d    = stack_top;
          acc_d   = literal_in;
          state_d = ST_DUMMY;
        end
        OPC_INTERRUPT_EXIT_OP: begin
          // with an irq pending the return address stays stacked, vector fetched instead
          pc_d    = take_irq ? PC_W'(`IRQ_VECTOR) : stack_top;
          emi_d   = !take_irq;
          state_d = ST_DUMMY;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_EXEC;
      pc_q    <= PC_W'(`PC_RESET);
      acc_q   <= `ACC_RESET;
      z_q     <= 1'b0;
      emi_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      acc_q   <= acc_d;
      z_q     <= z_d;
      emi_q   <= emi_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      we_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
    end else begin
      we_q    <= exec && op_in == OPC_ORA2M;
      waddr_q <= mem_addr_in;
      wdata_q <= or_mem;
    end
  end

  assign ready_out      = state_q == ST_EXEC;
  assign pc_out         = pc_q;
  assign acc_out        = acc_q;
  assign zero_flag_out  = z_q;
  assign int_enable_out = emi_q;
  assign mem_we_out     = we_q;
  assign mem_waddr_out  = waddr_q;
  assign mem_wdata_out  = wdata_q;

  sequence s_ret_issue;
    exec && is_ret;
  endsequence
  sequence s_dummy;
    !ready_out ##1 ready_out;
  endsequence
  sequence s_core_held;
    pc_q == $past(pc_q) && acc_q == $past(acc_q) && z_q == $past(z_q) && !mem_we_out;
  endsequence

  a_idle_pc_step: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_IDLE |=> pc_q == $past(pc_q) + 1'b1 && acc_q == $past(acc_q)
      && z_q == $past(z_q) && !mem_we_out) else $error("idle op changed state");
  a_or_mem_acc: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_ORM2A |=> acc_q == $past(or_mem) && z_q == ($past(or_mem) == 0))
    else $error("or memory into acc wrong");
  a_or_lit_acc: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_ORX2A |=> acc_q == $past(or_lit) && z_q == ($past(or_lit) == 0))
    else $error("or literal into acc wrong");
  a_or_mem_write: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_ORA2M |=> mem_we_out && mem_wdata_out == $past(or_mem)
      && acc_q == $past(acc_q)) else $error("or into memory wrong");
  a_ret_pc_load: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_RET |=> pc_q == $past(stack_top) && z_q == $past(z_q))
    else $error("return pc wrong");
  a_retx_acc: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_RETX |=> acc_q == $past(literal_in) && pc_q == $past(stack_top))
    else $error("literal return wrong");
  a_interrupt_exit_op_enable: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    exec && op_in == OPC_INTERRUPT_EXIT_OP && !irq_pending_in |=> int_enable_out && z_q == $past(z_q))
    else $error("interrupt return enable not set");
  a_interrupt_exit_op_pending: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    take_irq |=> pc_q == `IRQ_VECTOR && !int_enable_out) else $error("pending irq skipped");
  a_ret_dummy: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    s_ret_issue |=> s_dummy) else $error("return not two cycles");

  // dummy cycle hold and length, ready hold, and the state each instruction must leave alone or load
  a_dummy_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !ready_out |=> s_core_held) else $error("dummy cycle changed state");
  a_dummy_once: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !ready_out |=> ready_out) else $error("dummy cycle longer than one");
  a_ready_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ready_out && !op_valid_in |=> ready_out) else $error("ready dropped without a return");
  a_ret_only_pc: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_ret0 |=> acc_q == $past(acc_q) && int_enable_out == $past(int_enable_out)
      && !mem_we_out) else $error("plain return touched data");
  a_retx_flags: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_retx |=> z_q == $past(z_q) && int_enable_out == $past(int_enable_out)
      && !mem_we_out) else $error("literal return touched flags");
  a_interrupt_exit_op_pop: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_interrupt_exit_op && !irq_pending_in |=> pc_q == $past(stack_top) && acc_q == $past(acc_q))
    else $error("interrupt return pc wrong");
  a_interrupt_exit_op_stack: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    take_irq |=> stack_top == $past(stack_top)) else $error("return address lost on irq");
  a_enable_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !is_interrupt_exit_op |=> int_enable_out == $past(int_enable_out)) else $error("enable changed");
  a_ret_no_write: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_ret0 || is_retx || is_interrupt_exit_op |=> !mem_we_out) else $error("return wrote memory");
  a_or_pc_step: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_orm2a || is_orx2a || is_ora2m |=> pc_q == $past(pc_q) + 1'b1
      && int_enable_out == $past(int_enable_out)) else $error("or op pc or enable wrong");
  a_or_no_write: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_orm2a || is_orx2a || is_idle |=> !mem_we_out) else $error("or into acc wrote memory");
  a_ora2m_target: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    is_ora2m |=> mem_waddr_out == $past(mem_addr_in) && z_q == ($past(or_mem) == 0))
    else $error("or into memory address or zero wrong");
endmodule : or_ret_exec

// file: hdl/or_ret_pkg.sv
// types for the or/return execution block
// assumes or_ret_cfg.svh is on the include path
`include "or_ret_cfg.svh"
package or_ret_pkg;
  typedef enum logic [6:0] {
    OPC_IDLE = 7'h01,
    OPC_ORM2A = 7'h02,
    OPC_ORX2A = 7'h04,
    OPC_ORA2M = 7'h08,
    OPC_RET   = 7'h10,
    OPC_RETX  = 7'h20,
    OPC_INTERRUPT_EXIT_OP  = 7'h40
  } op_t;
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_DUMMY = 2'b10
  } state_t;
endpackage : or_ret_pkg

// file: hdl/ret_stack.sv
// return-address stack, flip-flop storage addressed by a pointer
// push and pop come from the core on the same clock
`timescale 1ns/1ps
`include "or_ret_cfg.svh"
module ret_stack #(
  parameter int WIDTH = `PC_W,
  parameter int DEPTH = `STACK_DEPTH
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  input  wire logic             pop_in,
  output logic      [WIDTH-1:0] top_out
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("ret_stack depth must be power of two >= 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    ptr_q;
  wire  [PW-1:0]    top_idx = ptr_q - 1'b1;
  assign top_out = mem_q[top_idx];
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ptr_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (push_in && pop_in) begin
      // pop and push in one cycle replace the top entry, pointer kept
      mem_q[top_idx] <= push_data_in;
    end else if (push_in) begin
      mem_q[ptr_q] <= push_data_in;
      ptr_q        <= ptr_q + 1'b1;
    end else if (pop_in) begin
      ptr_q <= top_idx;
    end
  end
endmodule : ret_stack

// file: testbench/or_logic_and_return_exec_tb.sv
// self-checking bench for the or/return execution block
// assumes an empty return stack after reset, so every pop yields 11'h000
`timescale 1ns/1ps
`include "or_ret_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module or_logic_and_return_exec_tb
  import or_ret_pkg::*;
;
  logic               core_clk_in = 1'b0;
  logic               reset_n_in  = 1'b0;
  logic               op_valid_in = 1'b0;
  op_t                op_in       = OPC_IDLE;
  logic [7:0]         literal_in  = 8'h00;
  logic [7:0]         mem_addr_in = 8'h00;
  logic [7:0]         mem_rdata_in = 8'h00;
  logic               irq_pending_in = 1'b0;
  logic               ready_out, zero_flag_out, int_enable_out, mem_we_out;
  logic [`PC_W-1:0]   pc_out;
  logic [7:0]         acc_out, mem_waddr_out, mem_wdata_out;
  int                 failures = 0;
  int                 n_tests  = 0;
  or_ret_exec DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .op_valid_in(op_valid_in), .op_in(op_in), .literal_in(literal_in),
    .mem_addr_in(mem_addr_in), .mem_rdata_in(mem_rdata_in),
    .irq_pending_in(irq_pending_in), .ready_out(ready_out), .pc_out(pc_out),
    .acc_out(acc_out), .zero_flag_out(zero_flag_out),
    .int_enable_out(int_enable_out), .mem_we_out(mem_we_out),
    .mem_waddr_out(mem_waddr_out), .mem_wdata_out(mem_wdata_out));
  always #2 core_clk_in = ~core_clk_in;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // presents one instruction for one accepting edge, called at a falling edge
  task automatic issue(input op_t op, input logic [7:0] lit, input logic [7:0] rd,
                       input logic irq);
    int i;
    i = 0;
    while (ready_out !== 1'b1 && i < 20) begin @(negedge core_clk_in); i++; end
    if (ready_out !== 1'b1) begin failures++; report_and_stop(); end
    op_in = op; literal_in = lit; mem_rdata_in = rd; irq_pending_in = irq;
    op_valid_in = 1'b1;
    @(negedge core_clk_in);
    op_valid_in = 1'b0;
    irq_pending_in = 1'b0;
  endtask : issue
  task automatic chk_state(input logic [`PC_W-1:0] p, input logic [7:0] a,
                           input logic z, input logic en);
    `CHK("pc", p, pc_out)
    `CHK("acc", a, acc_out)
    `CHK("zero", z, zero_flag_out)
    `CHK("enable", en, int_enable_out)
  endtask : chk_state
  // return: dummy cycle refuses an offered op, then ready comes back
  task automatic ret_case(input op_t op, input logic [7:0] lit, input logic irq,
                          input logic [`PC_W-1:0] p, input logic [7:0] a, input logic z,
                          input logic en);
    // an idle first moves pc off the stacked address so the reload shows
    issue(OPC_IDLE, 8'h00, 8'h00, 1'b0);
    issue(op, lit, 8'h00, irq);
    `CHK("ready dummy", 1'b0, ready_out)
    chk_state(p, a, z, en);
    op_in = OPC_ORX2A; literal_in = 8'hff; op_valid_in = 1'b1;
    @(negedge core_clk_in);
    op_valid_in = 1'b0;
    `CHK("ready back", 1'b1, ready_out)
    @(negedge core_clk_in);
    chk_state(p, a, z, en);
    $display("done return %s", op.name());
  endtask : ret_case
  task automatic t_reset();
    `CHK("ready rst", 1'b1, ready_out)
    chk_state(11'h000, 8'h00, 1'b0, 1'b0);
    $display("done reset");
  endtask : t_reset
  task automatic t_or_ops();
    issue(OPC_ORX2A, 8'h00, 8'h77, 1'b0);
    chk_state(11'h001, 8'h00, 1'b1, 1'b0);
    issue(OPC_ORX2A, 8'h5a, 8'h00, 1'b0);
    chk_state(11'h002, 8'h5a, 1'b0, 1'b0);
    issue(OPC_ORM2A, 8'h0f, 8'h81, 1'b0);
    chk_state(11'h003, 8'hdb, 1'b0, 1'b0);
    `CHK("we orm2a", 1'b0, mem_we_out)
    mem_addr_in = 8'h3c;
    issue(OPC_ORA2M, 8'h00, 8'h24, 1'b0);
    `CHK("we", 1'b1, mem_we_out)
    `CHK("waddr", 8'h3c, mem_waddr_out)
    `CHK("wdata", 8'hff, mem_wdata_out)
    chk_state(11'h004, 8'hdb, 1'b0, 1'b0);
    issue(OPC_IDLE, 8'hff, 8'hff, 1'b0);
    `CHK("we idle", 1'b0, mem_we_out)
    chk_state(11'h005, 8'hdb, 1'b0, 1'b0);
    $display("done or and idle");
  endtask : t_or_ops
  task automatic t_or_zero();
    issue(OPC_ORA2M, 8'h00, 8'h00, 1'b0);
    `CHK("wdata zero", 8'h00, mem_wdata_out)
    chk_state(11'h001, 8'h00, 1'b1, 1'b0);
    $display("done or zero");
  endtask : t_or_zero
  task automatic t_mid_reset();
    reset_n_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    @(negedge core_clk_in);
    t_reset();
  endtask : t_mid_reset
  initial begin
    repeat (16) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    @(negedge core_clk_in);
    t_reset();
    t_or_ops();
    ret_case(OPC_INTERRUPT_EXIT_OP, 8'h00, 1'b1, `IRQ_VECTOR, 8'hdb, 1'b0, 1'b0);
    ret_case(OPC_RETX, 8'h00, 1'b0, 11'h000, 8'h00, 1'b0, 1'b0);
    t_or_zero();
    ret_case(OPC_INTERRUPT_EXIT_OP, 8'h11, 1'b0, 11'h000, 8'h00, 1'b1, 1'b1);
    ret_case(OPC_RET, 8'h22, 1'b0, 11'h000, 8'h00, 1'b1, 1'b1);
    t_mid_reset();
    report_and_stop();
  end
endmodule : or_logic_and_return_exec_tb
